// *** hdl/fpc_pkg.sv ***
// fpc_pkg: constants, states and carrier structs for the flash power/reset controller
// assumes a 200 MHz system clock; the flash itself is clockless and driven by pins
package fpc_pkg;
	localparam int CLK_PERIOD_NS = 5;
	// recovery, shutdown, pulse, program and access times, as printed
	localparam int READ_RECOVERY_NS = 150;
	localparam int WRITE_RECOVERY_NS = 150;
	localparam int RESET_PULSE_NS = 100;
	localparam int ABORT_SHUTDOWN_US = 22;
	localparam int PROGRAM_MAX_US = 200;
	localparam int WRITE_PULSE_NS = 70;
	localparam int WRITE_HIGH_NS = 30;
	localparam int READ_ACCESS_NS = 70;
	// least times and the abort shutdown time round up, the longest program time rounds down
	localparam int READ_RECOVERY_CYC = (READ_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ABORT_SHUTDOWN_CYC = (ABORT_SHUTDOWN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROGRAM_MAX_CYC = (PROGRAM_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	localparam logic [15:0] STATUS_READY = 16'h0080;
	localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
	localparam logic [7:0] STATUS_READY_BIT = 8'h80;

	// one-hot controller states
	typedef enum logic [6:0] {
		ST_PWRDN = 7'h01,
		ST_RECOVER = 7'h02,
		ST_STANDBY = 7'h04,
		ST_READ = 7'h08,
		ST_WR_LOW = 7'h10,
		ST_WR_HIGH = 7'h20,
		ST_BUSY = 7'h40
	} fpc_state_t;

	// user request toward the flash
	typedef struct packed {
		logic rd;
		logic wr;
		logic [21:0] addr;
		logic [15:0] wdata;
	} fpc_req_t;

	// flash control pins, all active low
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic reset_powerdown_n;
	} fpc_pins_t;

	// whole controller state
	typedef struct packed {
		fpc_state_t st;
		fpc_pins_t pins;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] rd_gap;
		logic [CNT_W-1:0] wr_gap;
		logic [21:0] addr;
		logic [15:0] dq;
		logic dq_drive;
		logic [15:0] rdata;
		logic rvalid;
		logic wdone;
		logic prog_timeout;
		logic aborted;
	} fpc_regs_t;
endpackage

// *** hdl/fpc_ctrl.sv ***
// fpc_ctrl: host-side controller for an asynchronous NOR flash, power modes and reset
// assumes flash pins are sampled synchronously to clk_sys_i; dq is split into in/out/enable
// Rules from the datasheet this block is written to
// R1: select low with reset high puts the flash in active mode.
// R2: after a read with idle address the flash saves power, outputs stay valid.
// R3: select high means standby; flash data outputs float regardless of output enable.
// R4: a program or erase continues to completion even if select goes high.
// R5: reset low gives deep power-down; outputs float, memory deselected.
// R6: wait read recovery before reading and write recovery before writing after reset.
// R7: reset low during program or erase aborts it, leaving the target invalid.
// R8: reset low or power loss clears the flash status register.
// R9: a command write needs select and write strobe low; either high inhibits.
// R10: memory changes only after a complete valid two-cycle command sequence.
// R11: while reset is held low, all control inputs are ignored.
// R12: newer process word program finishes within 200 us low voltage, 185 us at 12 V.
// R13: older process word program finishes within 200 us, typical 22 us.
// R14: keep reset low while supplies ramp so no bus state starts an operation.
// R15: drive flash reset from processor reset so it returns to array reads.
// R16: after reset: array-read mode, status 0x80, all blocks locked.
// R17: reset during erase finishes shutdown within 22 us; recovery counts after that.
// R18: reset with no operation running completes within 100 ns.
// R19: power states active, power saving, standby, power-down; power-down wins.
module fpc_ctrl (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// user side
	input wire fpc_pkg::fpc_req_t req_i,
	input wire logic busy_cmd_i,
	input wire logic sleep_i,
	output logic ready_o,
	output logic [15:0] rdata_o,
	output logic rvalid_o,
	output logic wdone_o,
	output logic prog_timeout_o,
	output logic aborted_o,
	// flash pins
	output fpc_pkg::fpc_pins_t pins_o,
	output logic [21:0] addr_o,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic dq_oe_n_o
);
	fpc_pkg::fpc_regs_t r;
	fpc_pkg::fpc_regs_t next_r;

	function automatic logic [15:0] cyc(input int n);
		cyc = n[15:0];
	endfunction

	// next-state logic; power-down request overrides everything except the abort flag, which is kept when it comes in ST_RECOVER
	always_comb
	begin
		next_r = r;
		next_r.rvalid = 1'b0;
		next_r.wdone = 1'b0;
		if (r.rd_gap != '0)
			next_r.rd_gap = r.rd_gap - 16'h0001; // R6
		if (r.wr_gap != '0)
			next_r.wr_gap = r.wr_gap - 16'h0001; // R6
		if (sleep_i && r.st != fpc_pkg::ST_PWRDN)
		begin
			// R5 R7 R19: abort whatever runs; only an operation in ST_BUSY is noted
			next_r.aborted = (r.st == fpc_pkg::ST_BUSY);
			next_r.st = fpc_pkg::ST_PWRDN;
			next_r.pins = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_powerdown_n: 1'b0};
			next_r.dq_drive = 1'b0;
			next_r.cnt = (r.st == fpc_pkg::ST_BUSY) ? cyc(fpc_pkg::ABORT_SHUTDOWN_CYC)
				: cyc(fpc_pkg::RESET_PULSE_CYC); // R17 R18
		end
		else
		begin
			case (r.st)
				fpc_pkg::ST_PWRDN:
				begin
					// R11 R14: hold reset low for the full shutdown/pulse time
					if (r.cnt != '0)
						next_r.cnt = r.cnt - 16'h0001;
					else if (!sleep_i)
					begin
						next_r.pins.reset_powerdown_n = 1'b1;
						next_r.st = fpc_pkg::ST_RECOVER;
						next_r.rd_gap = cyc(fpc_pkg::READ_RECOVERY_CYC); // R6 R17
						next_r.wr_gap = cyc(fpc_pkg::WRITE_RECOVERY_CYC); // R6
					end
				end
				fpc_pkg::ST_RECOVER:
				begin
					if (r.rd_gap == '0 && r.wr_gap == '0)
						next_r.st = fpc_pkg::ST_STANDBY; // R16: flash back in array read
				end
				fpc_pkg::ST_STANDBY:
				begin
					next_r.pins.ce_n = 1'b1; // R3
					next_r.pins.oe_n = 1'b1;
					next_r.pins.we_n = 1'b1;
					next_r.dq_drive = 1'b0;
					if (req_i.wr)
					begin
						// R9: both select and strobe low for a write
						next_r.addr = req_i.addr;
						next_r.dq = req_i.wdata;
						next_r.dq_drive = 1'b1;
						next_r.pins.ce_n = 1'b0;
						next_r.pins.we_n = 1'b0;
						next_r.cnt = cyc(fpc_pkg::WRITE_PULSE_CYC);
						next_r.st = fpc_pkg::ST_WR_LOW;
					end
					else if (req_i.rd)
					begin
						// R1: select and output enable; select goes high after, so the flash drops to standby
						next_r.addr = req_i.addr;
						next_r.pins.ce_n = 1'b0;
						next_r.pins.oe_n = 1'b0;
						next_r.cnt = cyc(fpc_pkg::READ_ACCESS_CYC);
						next_r.st = fpc_pkg::ST_READ;
					end
				end
				fpc_pkg::ST_READ:
				begin
					if (r.cnt != '0)
						next_r.cnt = r.cnt - 16'h0001;
					else
					begin
						next_r.rdata = dq_i;
						next_r.rvalid = 1'b1;
						next_r.pins.oe_n = 1'b1;
						next_r.pins.ce_n = 1'b1;
						next_r.st = fpc_pkg::ST_STANDBY;
					end
				end
				fpc_pkg::ST_WR_LOW:
				begin
					if (r.cnt != '0)
						next_r.cnt = r.cnt - 16'h0001;
					else
					begin
						// data and address latch on this rising strobe edge
						next_r.pins.we_n = 1'b1; // R9
						next_r.cnt = cyc(fpc_pkg::WRITE_HIGH_CYC);
						next_r.st = fpc_pkg::ST_WR_HIGH;
					end
				end
				fpc_pkg::ST_WR_HIGH:
				begin
					if (r.cnt != '0)
						next_r.cnt = r.cnt - 16'h0001;
					else
					begin
						next_r.pins.ce_n = 1'b1;
						next_r.dq_drive = 1'b0;
						next_r.wdone = 1'b1;
						// R10: second cycle of a sequence starts the operation; poll status
						if (busy_cmd_i)
						begin
							next_r.cnt = cyc(fpc_pkg::PROGRAM_MAX_CYC);
							next_r.prog_timeout = 1'b0;
							next_r.st = fpc_pkg::ST_BUSY;
						end
						else
							next_r.st = fpc_pkg::ST_STANDBY;
					end
				end
				fpc_pkg::ST_BUSY:
				begin
					// R4: select and read status; device finishes even if deselected
					next_r.pins.ce_n = 1'b0;
					next_r.pins.oe_n = 1'b0;
					if (r.pins.oe_n == 1'b0 && dq_i[7] == fpc_pkg::STATUS_READY_BIT[7])
					begin
						next_r.pins.ce_n = 1'b1;
						next_r.pins.oe_n = 1'b1;
						next_r.rdata = dq_i;
						next_r.rvalid = 1'b1;
						next_r.st = fpc_pkg::ST_STANDBY;
					end
					else if (r.cnt != '0)
						next_r.cnt = r.cnt - 16'h0001;
					else
					begin
						// R12 R13: program overran its longest time
						next_r.prog_timeout = 1'b1;
						next_r.pins.ce_n = 1'b1;
						next_r.pins.oe_n = 1'b1;
						next_r.st = fpc_pkg::ST_STANDBY;
					end
				end
				default:
					next_r.st = fpc_pkg::ST_PWRDN;
			endcase
		end
		if (r.st == fpc_pkg::ST_RECOVER)
			next_r.aborted = r.aborted;
	end

	// state register; reset holds flash in power-down like the processor reset
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			r <= '0;
			r.st <= fpc_pkg::ST_PWRDN; // R15 R8
			r.pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_powerdown_n: 1'b0};
			r.cnt <= 16'(fpc_pkg::RESET_PULSE_CYC); // R18: same short pulse as a plain reset
		end
		else if (ce_i)
			r <= next_r;
	end

	// outputs
	assign pins_o = r.pins;
	assign addr_o = r.addr;
	assign dq_o = r.dq;
	assign dq_oe_n_o = ~r.dq_drive;
	assign rdata_o = r.rdata;
	assign rvalid_o = r.rvalid;
	assign wdone_o = r.wdone;
	assign prog_timeout_o = r.prog_timeout;
	assign aborted_o = r.aborted;
	assign ready_o = (r.st == fpc_pkg::ST_STANDBY) && !sleep_i;

	// assertions
	property p_write_strobe;
		@(posedge clk_sys_i) disable iff (rst_i)
		!r.pins.we_n |-> !r.pins.ce_n && r.pins.reset_powerdown_n && r.pins.oe_n;
	endproperty
	a_write_strobe: assert property (p_write_strobe) else $error("write strobe without select"); // R9

	property p_pd_quiet;
		@(posedge clk_sys_i) disable iff (rst_i)
		!r.pins.reset_powerdown_n |-> r.pins.ce_n && r.pins.we_n && !r.dq_drive;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("bus active in power-down"); // R11

	property p_sleep_wins;
		@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && sleep_i |=> !r.pins.reset_powerdown_n;
	endproperty
	a_sleep_wins: assert property (p_sleep_wins) else $error("power-down not taken"); // R19

	sequence s_release;
		$rose(r.pins.reset_powerdown_n);
	endsequence
	property p_recovery;
		@(posedge clk_sys_i) disable iff (rst_i)
		s_release |-> (r.pins.ce_n && r.pins.we_n) [*8];
	endproperty
	a_recovery: assert property (p_recovery) else $error("access before recovery"); // R6

	property p_min_pulse;
		@(posedge clk_sys_i) disable iff (rst_i || !ce_i)
		$fell(r.pins.reset_powerdown_n) |=> !r.pins.reset_powerdown_n [*8];
	endproperty
	a_min_pulse: assert property (p_min_pulse) else $error("reset pulse too short"); // R18

	property p_ready_ok;
		@(posedge clk_sys_i) disable iff (rst_i)
		ready_o |-> r.pins.reset_powerdown_n && r.rd_gap == '0 && r.wr_gap == '0;
	endproperty
	a_ready_ok: assert property (p_ready_ok) else $error("ready during recovery"); // R6

	property p_standby_float;
		@(posedge clk_sys_i) disable iff (rst_i)
		r.st == fpc_pkg::ST_STANDBY && r.pins.ce_n |-> !r.dq_drive;
	endproperty
	a_standby_float: assert property (p_standby_float) else $error("dq driven in standby"); // R3

	property p_abort_flag;
		@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && sleep_i && r.st == fpc_pkg::ST_BUSY |=> aborted_o;
	endproperty
	a_abort_flag: assert property (p_abort_flag) else $error("abort not flagged"); // R7
endmodule // fpc_ctrl

// *** testbench/fpc_flash_model.sv ***
// fpc_flash_model: behavioural flash device behind the controller pins
// assumes the resolved data bus comes back on dq_i; program time set by the bench
module fpc_flash_model (
	// control pins and address
	input wire fpc_pkg::fpc_pins_t pins_i,
	input wire logic [21:0] addr_i,
	// data bus, program time
	input wire logic [15:0] dq_i,
	input var int prog_ns_i,
	output logic [15:0] dq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:15];
	logic [15:0] sr = 16'h0080;
	logic [15:0] last = 16'h0000;
	logic stat_mode = 1'b0;
	logic setup = 1'b0;
	logic busy = 1'b0;
	logic [3:0] prog_a = 4'h0;
	int tok = 0;
	wire logic wact = !pins_i.ce_n && !pins_i.we_n;
	// power-down is tested first, it beats every other state
	wire logic rd_en = pins_i.reset_powerdown_n && !pins_i.ce_n && !pins_i.oe_n && !wact;
	initial
	begin
		for (int i = 0; i < 16; i++)
			mem[i] = 16'hffff;
	end
	// program runs on its own; select going high does not stop it
	task automatic start_prog(input logic [15:0] d);
		int my;
		my = tok + 1;
		tok = my;
		prog_a = addr_i[3:0];
		busy = 1'b1;
		sr = 16'h0000;
		stat_mode = 1'b1;
		fork
		begin
			#(prog_ns_i);
			if (tok == my)
			begin
				mem[prog_a] = d;
				busy = 1'b0;
				sr = 16'h0080;
			end
		end
		join_none
	endtask
	// commands latch at the end of a write pulse
	always @(negedge wact)
	begin
		if (pins_i.reset_powerdown_n === 1'b1 && !busy)
		begin
			if (setup)
				start_prog(dq_i);
			else
				stat_mode = (dq_i[7:0] == 8'h70);
			setup = (dq_i[7:0] == 8'h40) && !setup;
		end
	end
	// reset low kills a running program, clears status
	always @(negedge pins_i.reset_powerdown_n)
	begin
		if (busy)
			mem[prog_a] = 16'h0bad;
		tok = tok + 1;
		busy = 1'b0;
		sr = 16'h0000;
		setup = 1'b0;
		stat_mode = 1'b0;
	end
	always @(posedge pins_i.reset_powerdown_n)
		sr = 16'h0080;
	// a floating bus shows the inverse of its last value, never a stale match
	always @*
	begin
		if (rd_en)
		begin
			dq_o = stat_mode ? sr : mem[addr_i[3:0]];
			last = dq_o;
		end
		else
			dq_o = ~last;
	end
endmodule // fpc_flash_model

// *** testbench/fpc_ctrl_tb.sv ***
// fpc_ctrl_tb: self-checking bench, controller against the flash model
// assumes the design package is compiled first; one 200 MHz clock
module fpc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic rst_i;
	logic sleep_i = 1'b0;
	logic busy_cmd_i = 1'b0;
	logic ce_i = 1'b1;
	fpc_pkg::fpc_req_t req_i = '0;
	fpc_pkg::fpc_pins_t pins_o;
	logic ready_o, rvalid_o, wdone_o, prog_timeout_o, aborted_o, dq_oe_n_o;
	logic [15:0] rdata_o, dq_o, fq, dq_i;
	logic [21:0] addr_o;
	int prog_ns = 1000;
	int n_fail = 0;
	int comparisons = 0;
	int n;
	assign dq_i = dq_oe_n_o ? fq : dq_o;
	always #2.5 clk_sys_i = ~clk_sys_i;
	fpc_ctrl dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .busy_cmd_i(busy_cmd_i),
		.sleep_i(sleep_i), .ready_o(ready_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .wdone_o(wdone_o),
		.prog_timeout_o(prog_timeout_o), .aborted_o(aborted_o), .pins_o(pins_o), .addr_o(addr_o),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
	fpc_flash_model flash (.pins_i(pins_o), .addr_i(addr_o), .dq_i(dq_i), .prog_ns_i(prog_ns), .dq_o(fq));
	task automatic give_verdict();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// 0 ready, 1 read valid, 2 flash reset high, 3 flash reset low, 4 write done
	function automatic logic sig(input int s);
		return s == 0 ? ready_o : s == 1 ? rvalid_o : s == 2 ? pins_o.reset_powerdown_n
			: s == 3 ? !pins_o.reset_powerdown_n : wdone_o;
	endfunction
	// bounded wait, cycles waited in n
	task automatic await(input int s, input int lim);
		for (n = 0; n < lim && sig(s) !== 1'b1; n++)
			@(negedge clk_sys_i);
		chk("awaited level", 16'h0001, {15'h0, sig(s)});
	endtask
	// request held across the taking edge; busy_cmd_i stays up, it is read at the end of the write
	task automatic issue(input logic rd, input logic busy, input logic [21:0] a, input logic [15:0] d);
		await(0, 50000);
		req_i = '{rd: rd, wr: !rd, addr: a, wdata: d};
		busy_cmd_i = busy;
		@(negedge clk_sys_i);
		req_i = '0;
		if (!rd)
			await(4, 40);
	endtask
	task automatic rd_chk(input logic [21:0] a, input logic [15:0] exp);
		issue(1'b1, 1'b0, a, 16'h0000);
		await(1, 40);
		chk("read data", exp, rdata_o);
	endtask
	task automatic t_reset();
		repeat (6) @(negedge clk_sys_i);
		chk("pins in reset", 16'h000e, {12'h0, pins_o});
		chk("bus released in reset", 16'h0001, {15'h0, dq_oe_n_o});
		rst_i = 1'b0;
		await(2, 100);
		await(0, 100);
		chk("recovery span", 16'h0001, {15'h0, n >= fpc_pkg::READ_RECOVERY_CYC - 1});
	endtask
	task automatic t_prog(input logic [21:0] a, input logic [15:0] d);
		issue(1'b0, 1'b0, a, 16'h0040);
		issue(1'b0, 1'b1, a, d);
		await(0, 45000);
		chk("timeout flag", 16'h0000, {15'h0, prog_timeout_o});
		chk("final status", fpc_pkg::STATUS_READY, rdata_o);
		issue(1'b0, 1'b0, a, 16'h00ff);
		rd_chk(a, d);
		chk("standby pins", 16'h000f, {12'h0, pins_o});
	endtask
	// enable low in mid-read: pins hold, no answer, read resumes intact
	task automatic t_freeze();
		issue(1'b1, 1'b0, 22'h000000, 16'h0000);
		ce_i = 1'b0;
		repeat (20) @(negedge clk_sys_i);
		chk("frozen pins", 16'h0003, {12'h0, pins_o});
		chk("frozen read valid", 16'h0000, {15'h0, rvalid_o});
		ce_i = 1'b1;
		await(1, 40);
		chk("read after freeze", 16'ha5c3, rdata_o);
	endtask
	// sleep in mid-program: abort, long shutdown, fresh status
	task automatic t_abort();
		prog_ns = 100000;
		issue(1'b0, 1'b0, 22'h000005, 16'h0040);
		issue(1'b0, 1'b1, 22'h000005, 16'h1111);
		repeat (200) @(negedge clk_sys_i);
		sleep_i = 1'b1;
		await(3, 10);
		chk("ready in power-down", 16'h0000, {15'h0, ready_o});
		sleep_i = 1'b0;
		await(2, 6000);
		chk("shutdown span", 16'h0001, {15'h0, n >= fpc_pkg::ABORT_SHUTDOWN_CYC - 1});
		chk("abort flag", 16'h0001, {15'h0, aborted_o});
		rd_chk(22'h000005, 16'h0bad);
		issue(1'b0, 1'b0, 22'h000000, 16'h0070);
		rd_chk(22'h000000, 16'h0080);
	endtask
	// a program slower than the limit must be flagged
	task automatic t_timeout();
		prog_ns = 250000;
		issue(1'b0, 1'b0, 22'h000007, 16'h0040);
		issue(1'b0, 1'b1, 22'h000007, 16'h2222);
		await(0, 45000);
		chk("poll span", 16'h0001, {15'h0, n >= fpc_pkg::PROGRAM_MAX_CYC - 1});
		chk("timeout flag", 16'h0001, {15'h0, prog_timeout_o});
	endtask
	initial
	begin
		rst_i = 1'b1;
		t_reset();
		t_prog(22'h000000, 16'ha5c3);
		t_prog(22'h3fffff, 16'h0000);
		t_freeze();
		t_abort();
		t_timeout();
		give_verdict();
	end
	// hang guard, well past the longest program wait
	initial
	begin
		#400us;
		n_fail++;
		give_verdict();
	end
endmodule // fpc_ctrl_tb
